//--- hdl/irq_prio_defs.svh
`ifndef IRQ_PRIO_DEFS_SVH
`define IRQ_PRIO_DEFS_SVH

// -----------------------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------------------
`define OFS_PRIO_19   8'h00
`define OFS_PRIO_20   8'h04
`define OFS_PRIO_21   8'h08
`define OFS_PRIO_22   8'h0C
`define OFS_PRIO_26   8'h10
`define OFS_PRIO_29   8'h14
`define OFS_TEST      8'h18
`define OFS_EVT_STAT  8'h1C
`define OFS_EVT_MASK  8'h20

// -----------------------------------------------------------------------------
// Field positions and values
// -----------------------------------------------------------------------------
`define LSB_HI        12
`define LSB_MID       8
`define LSB_LO4       4
`define LSB_LO0       0
`define PRIO_W        3
`define PRIO_RESET    3'h4
`define PRIO_OFF      3'h0
`define TST_PEND_BIT  15
`define TST_RSVD_BIT  14
`define TST_HOLD_BIT  13
`define TST_GAP_BIT   12
`define TST_LVL_LSB   8
`define TST_VEC_LSB   0
`define VEC_MAX       8'h76
`define EVT_REQ       0
`define EVT_ACK       1
`define EVT_W         2

// -----------------------------------------------------------------------------
// Source indices
// -----------------------------------------------------------------------------
`define SRC_COUNT     14
`define SRC_CHARGE    0
`define SRC_S3_TX     1
`define SRC_S3_RX     2
`define SRC_S3_ERR    3
`define SRC_S4_ERR    4
`define SRC_USB       5
`define SRC_I2C_B     6
`define SRC_I2C_A     7
`define SRC_SPI_TX    8
`define SRC_SPI_GEN   9
`define SRC_S4_TX     10
`define SRC_S4_RX     11
`define SRC_SELFTUNE  12
`define SRC_JTAG      13

`endif

//--- hdl/irq_prio_pkg.sv
package irq_prio_pkg;

   typedef logic [2:0]  prio_t;
   typedef logic [3:0]  level_t;
   typedef logic [7:0]  vec_t;
   typedef logic [15:0] word_t;

   typedef enum logic {
      BUS_IDLE,
      BUS_ANSWER
   } bus_state_t;

endpackage

//--- hdl/irq_prio_regs.sv
`timescale 1ns/100ps
`include "irq_prio_defs.svh"

module irq_prio_regs import irq_prio_pkg::*; #(
   parameter int   N        = `SRC_COUNT,
   parameter vec_t VEC_BASE = 8'h50
) (
   input  wire logic        ref_clk_i,   // System clock, 125 MHz.
   input  wire logic        nrst_i,      // Asynchronous reset, active low.
   input  wire logic        ce_i,        // Clock enable, freezes state when low.
   input  wire logic        wb_cyc_i,    // Bus cycle.
   input  wire logic        wb_stb_i,    // Bus strobe.
   input  wire logic        wb_we_i,     // Bus write enable.
   input  wire logic [7:0]  wb_adr_i,    // Byte address.
   input  wire logic [3:0]  wb_sel_i,    // Byte lane selects.
   input  wire logic [31:0] wb_dat_i,    // Write data.
   output logic      [31:0] wb_dat_o,    // Read data.
   output logic             wb_ack_o,    // Bus acknowledge.
   input  wire logic [N-1:0] src_req_i,  // Source requests, flag and enable.
   input  wire level_t      cpu_level_i, // Current CPU priority level.
   input  wire logic        cpu_ack_i,   // CPU takes the request.
   output logic             cpu_irq_o,   // Request to the CPU.
   output vec_t             cpu_vec_o,   // Vector of the request.
   output level_t           cpu_level_o, // New CPU level field.
   output logic             irq_o        // Event interrupt, level.
);

   // -------------------------------------------------------------------------
   // Field map
   // -------------------------------------------------------------------------
   function automatic logic [7:0] src_ofs(input int i);
      case (i)
         `SRC_CHARGE:                                     src_ofs = `OFS_PRIO_19;
         `SRC_S3_TX, `SRC_S3_RX, `SRC_S3_ERR:              src_ofs = `OFS_PRIO_20;
         `SRC_S4_ERR, `SRC_USB, `SRC_I2C_B, `SRC_I2C_A:    src_ofs = `OFS_PRIO_21;
         `SRC_SPI_TX, `SRC_SPI_GEN, `SRC_S4_TX, `SRC_S4_RX: src_ofs = `OFS_PRIO_22;
         `SRC_SELFTUNE:                                   src_ofs = `OFS_PRIO_26;
         default:                                         src_ofs = `OFS_PRIO_29;
      endcase
   endfunction

   function automatic int src_lsb(input int i);
      case (i)
         `SRC_S3_TX, `SRC_S4_ERR, `SRC_SPI_TX:                 src_lsb = `LSB_HI;
         `SRC_S3_RX, `SRC_USB, `SRC_SPI_GEN, `SRC_SELFTUNE:    src_lsb = `LSB_MID;
         `SRC_I2C_A, `SRC_S4_RX:                               src_lsb = `LSB_LO0;
         default:                                              src_lsb = `LSB_LO4;
      endcase
   endfunction

   // -------------------------------------------------------------------------
   // Reset and state
   // -------------------------------------------------------------------------
   logic          rst_n;
   bus_state_t    bus_state;
   bus_state_t    next_bus_state;
   prio_t         prio_q [N];
   logic [3*N-1:0] prio_flat;
   logic          hold_q;
   level_t        level_q;
   vec_t          ack_vec_q;
   logic          pend_q;
   vec_t          pend_vec_q;
   prio_t         pend_prio_q;
   logic [`EVT_W-1:0] evt_stat;
   logic [`EVT_W-1:0] evt_mask;
   word_t         rd_q;
   word_t         rd_word;

   rst_sync u_rst_sync (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .rst_n_o   (rst_n)
   );

   // -------------------------------------------------------------------------
   // Arbitration
   // -------------------------------------------------------------------------
   logic   win_valid;
   logic [7:0] win_idx;
   prio_t  win_prio;
   logic   win_ok;
   vec_t   win_vec;

   always_comb begin
      for (int i = 0; i < N; i++) begin
         prio_flat[3*i +: 3] = prio_q[i];
      end
   end

   prio_pick #(
      .N (N)
   ) u_pick (
      .req_i   (src_req_i),
      .prio_i  (prio_flat),
      .valid_o (win_valid),
      .idx_o   (win_idx),
      .prio_o  (win_prio)
   );

   assign win_ok  = win_valid && ({1'b0, win_prio} > cpu_level_i);
   assign win_vec = vec_t'(VEC_BASE + win_idx);

   // -------------------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------------------
   wire [7:0] adr_word  = {wb_adr_i[7:2], 2'b00};
   wire       bus_req   = wb_cyc_i && wb_stb_i;
   wire       wr_stb    = bus_req && wb_we_i && (bus_state == BUS_ANSWER) && ce_i;
   wire       hit_test  = (adr_word == `OFS_TEST);
   wire       hit_stat  = (adr_word == `OFS_EVT_STAT);
   wire       hit_mask  = (adr_word == `OFS_EVT_MASK);
   wire       wr_lo     = wr_stb && wb_sel_i[0];
   wire       wr_hi     = wr_stb && wb_sel_i[1];
   wire       cpu_take  = cpu_ack_i && pend_q && ce_i;
   wire       next_pend = win_ok && !cpu_take;
   wire [`EVT_W-1:0] evt_set = {cpu_take, next_pend && !pend_q && ce_i};
   wire [`EVT_W-1:0] evt_clr = (wr_lo && hit_stat) ? wb_dat_i[`EVT_W-1:0] : '0;

   // Captured vector shown in the test register.
   wire vec_t shown_vec = hold_q ? pend_vec_q : ack_vec_q;

   always_comb begin
      rd_word = 16'h0000;
      for (int i = 0; i < N; i++) begin
         if (src_ofs(i) == adr_word) begin
            rd_word[src_lsb(i) +: `PRIO_W] = prio_q[i];
         end
      end
      if (hit_test) begin
         rd_word[`TST_PEND_BIT]              = pend_q;
         rd_word[`TST_HOLD_BIT]              = hold_q;
         rd_word[`TST_LVL_LSB +: 4]          = level_q;
         rd_word[`TST_VEC_LSB +: 8]          = shown_vec;
      end
      if (hit_stat) begin
         rd_word[`EVT_W-1:0] = evt_stat;
      end
      if (hit_mask) begin
         rd_word[`EVT_W-1:0] = evt_mask;
      end
   end

   // -------------------------------------------------------------------------
   // Bus answer, one wait state
   // -------------------------------------------------------------------------
   always_comb begin
      case (bus_state)
         BUS_IDLE:   next_bus_state = bus_req ? BUS_ANSWER : BUS_IDLE;
         BUS_ANSWER: next_bus_state = BUS_IDLE;
         default:    next_bus_state = BUS_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         bus_state <= BUS_IDLE;
         rd_q      <= 16'h0000;
      end else if (ce_i) begin
         bus_state <= next_bus_state;
         if (bus_state == BUS_IDLE && bus_req) begin
            rd_q <= rd_word;
         end
      end
   end

   assign wb_ack_o = (bus_state == BUS_ANSWER);
   assign wb_dat_o = {16'h0000, rd_q};

   // -------------------------------------------------------------------------
   // Priority fields
   // -------------------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < N; i++) begin
            prio_q[i] <= `PRIO_RESET;
         end
      end else begin
         for (int i = 0; i < N; i++) begin
            if (src_ofs(i) == adr_word &&
                (src_lsb(i) >= `LSB_MID ? wr_hi : wr_lo)) begin
               prio_q[i] <= wb_dat_i[src_lsb(i) +: `PRIO_W];
            end
         end
      end
   end

   // -------------------------------------------------------------------------
   // Test register and CPU request
   // -------------------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         hold_q      <= 1'b0;
         level_q     <= 4'h0;
         ack_vec_q   <= 8'h00;
         pend_q      <= 1'b0;
         pend_vec_q  <= 8'h00;
         pend_prio_q <= `PRIO_OFF;
      end else if (ce_i) begin
         pend_q <= next_pend;
         if (win_ok) begin
            pend_vec_q  <= win_vec;
            pend_prio_q <= win_prio;
         end
         if (wr_hi && hit_test) begin
            hold_q  <= wb_dat_i[`TST_HOLD_BIT];
            level_q <= wb_dat_i[`TST_LVL_LSB +: 4];
         end
         if (wr_lo && hit_test) begin
            ack_vec_q <= wb_dat_i[`TST_VEC_LSB +: 8];
         end
         if (cpu_take) begin
            ack_vec_q <= pend_vec_q;
            level_q   <= {1'b0, pend_prio_q};
         end
      end
   end

   assign cpu_irq_o   = pend_q;
   assign cpu_vec_o   = pend_vec_q;
   assign cpu_level_o = level_q;

   // -------------------------------------------------------------------------
   // Event status, write one to clear
   // -------------------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         evt_stat <= '0;
         evt_mask <= '0;
      end else if (ce_i) begin
         evt_stat <= (evt_stat & ~evt_clr) | evt_set;
         if (wr_lo && hit_mask) begin
            evt_mask <= wb_dat_i[`EVT_W-1:0];
         end
      end
   end

   assign irq_o = |(evt_stat & evt_mask);

   // -------------------------------------------------------------------------
   // Checker helpers
   // -------------------------------------------------------------------------
   // Raised when a requesting source outranks the winner, or ties with it at a
   // lower index; either breaks the arbitration order.
   logic order_bad;

   always_comb begin
      order_bad = 1'b0;
      for (int i = 0; i < N; i++) begin
         if (src_req_i[i] && prio_q[i] > win_prio) begin
            order_bad = 1'b1;
         end
         if (src_req_i[i] && win_valid && prio_q[i] == win_prio && 8'(i) < win_idx) begin
            order_bad = 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n);

   AST_DISABLED_NEVER_WINS: assert property (
      win_valid |-> win_prio != `PRIO_OFF)
      else $error("disabled source won arbitration");

   AST_REQ_ABOVE_LEVEL: assert property (
      $rose(cpu_irq_o) |-> {1'b0, $past(win_prio)} > $past(cpu_level_i))
      else $error("request raised at or below cpu level");

   AST_UPPER_ZERO: assert property (
      wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
      else $error("upper data bits not zero");

   AST_TEST_GAPS_ZERO: assert property (
      wb_ack_o && !wb_we_i && hit_test |->
         !wb_dat_o[`TST_RSVD_BIT] && !wb_dat_o[`TST_GAP_BIT])
      else $error("reserved test bits read nonzero");

   AST_PEND_READ: assert property (
      wb_ack_o && hit_test && $past(ce_i) |-> wb_dat_o[`TST_PEND_BIT] == $past(pend_q))
      else $error("request flag read mismatch");

   AST_HOLD_VECTOR: assert property (
      wb_ack_o && hit_test && $past(ce_i) |->
         wb_dat_o[7:0] == ($past(hold_q) ? $past(pend_vec_q) : $past(ack_vec_q)))
      else $error("vector field follows wrong capture");

   AST_ACK_LOADS_LEVEL: assert property (
      cpu_take |=> level_q == {1'b0, $past(pend_prio_q)} && ack_vec_q == $past(pend_vec_q))
      else $error("acknowledge did not load level and vector");

   AST_ONE_WAIT_ACK: assert property (
      bus_req && !wb_ack_o && ce_i ##1 ce_i |-> wb_ack_o ##1 !wb_ack_o)
      else $error("bus answer timing wrong");

   AST_RESET_LEVEL4: assert property (
      $rose(rst_n) |-> prio_q[`SRC_JTAG] == `PRIO_RESET && prio_q[`SRC_CHARGE] == `PRIO_RESET)
      else $error("priority field not reset to level four");

   AST_FIELD_WRITE: assert property (
      wr_hi && adr_word == `OFS_PRIO_20 |=>
         prio_q[`SRC_S3_RX] == $past(wb_dat_i[10:8]))
      else $error("receive priority field not written");

   AST_WINNER_HIGHEST: assert property (
      !order_bad)
      else $error("arbitration picked a lower priority source");

   AST_NO_WIN_NO_REQ: assert property (
      ce_i && !win_ok |=> !cpu_irq_o)
      else $error("request raised without an eligible source");

   AST_TAKE_DROPS_REQ: assert property (
      cpu_take |=> !cpu_irq_o)
      else $error("request flag stayed set after acknowledge");

   AST_REQ_EVENT_SET: assert property (
      evt_set[`EVT_REQ] |=> evt_stat[`EVT_REQ])
      else $error("request event not recorded");

   AST_ACK_EVENT_SET: assert property (
      cpu_take |=> evt_stat[`EVT_ACK])
      else $error("acknowledge event not recorded");

   AST_SPARSE_REGS_ZERO: assert property (
      wb_ack_o && (adr_word == `OFS_PRIO_19 || adr_word == `OFS_PRIO_29) |->
         (wb_dat_o[15:0] & 16'hFF8F) == 16'h0000)
      else $error("unimplemented bits read nonzero");

   AST_SELFTUNE_ONLY: assert property (
      wb_ack_o && adr_word == `OFS_PRIO_26 |-> (wb_dat_o[15:0] & 16'hF8FF) == 16'h0000)
      else $error("unimplemented self-tune register bits read nonzero");

   AST_HOLD_WRITE: assert property (
      wr_hi && hit_test |=> hold_q == $past(wb_dat_i[`TST_HOLD_BIT]))
      else $error("capture select not written");

   AST_LEVEL_HOLDS: assert property (
      !cpu_take && !(wr_hi && hit_test) |=> $stable(level_q))
      else $error("new cpu level changed without a cause");

   AST_VEC_RANGE: assert property (
      cpu_irq_o |-> cpu_vec_o <= `VEC_MAX)
      else $error("vector number out of range");

   COV_REQ_ACK:  cover property (cpu_take ##1 !cpu_irq_o);
   COV_HOLD_READ: cover property (wb_ack_o && hit_test && hold_q);
   COV_EVT_IRQ:  cover property ($rose(irq_o));
   COV_BLOCKED:  cover property (win_valid && !win_ok);
   COV_MULTI_REQ: cover property (win_valid && $countones(src_req_i) > 1);

endmodule // irq_prio_regs

//--- hdl/prio_pick.sv
`timescale 1ns/100ps
`include "irq_prio_defs.svh"

module prio_pick import irq_prio_pkg::*; #(
   parameter int N = 14
) (
   input  wire logic [N-1:0]   req_i,   // Pending and enabled sources.
   input  wire logic [3*N-1:0] prio_i,  // Packed priority fields.
   output logic                valid_o, // A source with nonzero priority waits.
   output logic [7:0]          idx_o,   // Index of the winner.
   output prio_t               prio_o   // Priority of the winner.
);

   // Highest level wins; ties go to the lowest index.
   always_comb begin
      prio_t cand;
      cand    = `PRIO_OFF;
      valid_o = 1'b0;
      idx_o   = 8'h00;
      prio_o  = `PRIO_OFF;
      for (int i = 0; i < N; i++) begin
         cand = prio_i[3*i +: 3];
         if (req_i[i] && cand != `PRIO_OFF && cand > prio_o) begin
            valid_o = 1'b1;
            idx_o   = 8'(i);
            prio_o  = cand;
         end
      end
   end

endmodule // prio_pick

//--- hdl/rst_sync.sv
`timescale 1ns/100ps

module rst_sync (
   input  wire logic ref_clk_i, // System clock.
   input  wire logic nrst_i,    // Asynchronous reset, active low.
   output logic      rst_n_o    // Synchronised reset, active low.
);

   logic stage1;
   logic stage2;

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
      end else begin
         stage1 <= 1'b1;
         stage2 <= stage1;
      end
   end

   assign rst_n_o = stage2;

endmodule // rst_sync

//--- test/cpu_core_model.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Processor core that takes requests after a chosen wait.
// ----------------------------------------------------------------
module cpu_core_model import irq_prio_pkg::*; (
   input  wire logic       ref_clk_i, // System clock.
   input  wire logic       rst_n_i,   // Reset, active low.
   input  wire logic       irq_i,     // Request from the controller.
   input  wire logic       en_i,      // Take requests while high.
   input  wire logic [1:0] wait_i,    // Cycles to wait before taking.
   input  wire level_t     base_i,    // Level outside a handler.
   output logic            ack_o,     // Acknowledge, one cycle.
   output level_t          level_o    // Current core level.
);
   logic [1:0] cnt;
   logic       in_isr;

   // Inside a handler the level sits at 15 so that nothing preempts it.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_o <= 1'b0;
         cnt <= 2'h0;
         in_isr <= 1'b0;
         level_o <= 4'h0;
      end else begin
         ack_o <= 1'b0;
         if (!en_i) begin
            in_isr <= 1'b0;
         end
         if (ack_o) begin
            in_isr <= 1'b1;
         end
         level_o <= (in_isr || ack_o) ? 4'hF : base_i;
         if (en_i && irq_i && !in_isr && !ack_o) begin
            cnt <= cnt + 2'h1;
            if (cnt >= wait_i) begin
               ack_o <= 1'b1;
               cnt <= 2'h0;
            end
         end
      end
   end
endmodule // cpu_core_model

//--- test/interrupt_priority_and_test_regs_test.sv
`timescale 1ns/100ps
`include "irq_prio_defs.svh"

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module interrupt_priority_and_test_regs_test import irq_prio_pkg::*;;
   localparam vec_t  vec_base = 8'h50;
   localparam word_t rv [6] = '{16'h0040, 16'h4440, 16'h4444, 16'h4444, 16'h0400, 16'h0040};
   localparam word_t mk [6] = '{16'h0070, 16'h7770, 16'h7777, 16'h7777, 16'h0700, 16'h0070};
   localparam int    ri [14] = '{0, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3, 4, 5};
   localparam int    lsb [14] = '{4, 12, 8, 4, 12, 8, 4, 0, 12, 8, 4, 0, 8, 4};

   logic        ref_clk = 1'b0;
   logic        nrst    = 1'b0;
   logic        cyc     = 1'b0;
   logic        stb     = 1'b0;
   logic        we      = 1'b0;
   logic [7:0]  adr     = 8'h00;
   logic [31:0] wdat    = 32'h0000_0000;
   logic [13:0] src     = 14'h0000;
   level_t      base    = 4'h0;
   logic        en      = 1'b0;
   logic [1:0]  wt      = 2'h0;
   logic [3:0]  sel     = 4'h3;
   logic        ce      = 1'b1;
   logic [31:0] rdat;
   logic        ack;
   logic        cpu_irq;
   logic        cpu_ack;
   logic        irq;
   vec_t        cpu_vec;
   level_t      new_lvl;
   level_t      cpu_lvl;
   int          compares = 0;
   int          fails    = 0;
   word_t       sh [6];
   word_t       q;
   int          idx;
   int          n;
   logic        exp_irq;
   logic        a;
   vec_t        exp_q [$];
   vec_t        ev;

   always #4 ref_clk = ~ref_clk;

   irq_prio_regs irq_prio_regs_i (
      .ref_clk_i(ref_clk), .nrst_i(nrst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .src_req_i(src), .cpu_level_i(cpu_lvl), .cpu_ack_i(cpu_ack),
      .cpu_irq_o(cpu_irq), .cpu_vec_o(cpu_vec), .cpu_level_o(new_lvl), .irq_o(irq));

   cpu_core_model cpu_core_model_i (
      .ref_clk_i(ref_clk), .rst_n_i(nrst), .irq_i(cpu_irq), .en_i(en), .wait_i(wt),
      .base_i(base), .ack_o(cpu_ack), .level_o(cpu_lvl));

   // ----------------------------------------------------------------
   // Reference arbiter and bus tasks
   // ----------------------------------------------------------------
   function automatic logic win(input logic [13:0] r, input level_t l, output int w);
      int bp;
      int p;
      bp = 0;
      w = 0;
      for (int s = 0; s < 14; s++) begin
         p = int'(sh[ri[s]] >> lsb[s]) & 7;
         if (r[s] && p > bp) begin
            bp = p;
            w = s;
         end
      end
      return bp > int'(l);
   endfunction

   task automatic summarize;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic wb(input logic w, input logic [7:0] ad, input word_t d, output word_t r);
      int k;
      k = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= {16'h0000, d};
      @(posedge ref_clk);
      while (ack !== 1'b1 && k < 20) begin
         @(posedge ref_clk);
         k++;
      end
      if (k >= 20) begin
         fails++;
         $display("[ERR] %0t bus answer missing", $time);
         summarize();
      end else begin
         r = rdat[15:0];
         `CHK(k, 1)
         cyc <= 1'b0;
         stb <= 1'b0;
         @(posedge ref_clk);
      end
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'h0000_03cb));
      repeat (10) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      for (int i = 0; i < 6; i++) begin
         wb(1'b0, 8'(4 * i), 16'h0000, q);
         `CHK(q, rv[i])
         wb(1'b1, 8'(4 * i), 16'hFFFF, q);
         wb(1'b0, 8'(4 * i), 16'h0000, q);
         `CHK(q, mk[i])
      end
      wb(1'b0, `OFS_TEST, 16'h0000, q);
      `CHK(q, 16'h0000)
      wb(1'b0, 8'h30, 16'h0000, q);
      `CHK(q, 16'h0000)
      sel <= 4'h1;
      wb(1'b1, `OFS_PRIO_20, 16'h0000, q);
      sel <= 4'h3;
      wb(1'b0, `OFS_PRIO_20, 16'h0000, q);
      `CHK(q, 16'h7700)
      repeat (24) begin
         src <= 14'h0000;
         repeat (3) @(posedge ref_clk);
         for (int i = 0; i < 6; i++) begin
            sh[i] = 16'($urandom) & mk[i];
            wb(1'b1, 8'(4 * i), 16'($urandom) | sh[i], q);
            wb(1'b1, 8'(4 * i), sh[i], q);
            wb(1'b0, 8'(4 * i), 16'h0000, q);
            `CHK(q, sh[i])
         end
         src <= 14'($urandom);
         base <= level_t'($urandom_range(0, 7));
         repeat (4) @(posedge ref_clk);
         exp_irq = win(src, base, idx);
         `CHK(cpu_irq, exp_irq)
         if (exp_irq) begin
            exp_q.push_back(vec_t'(vec_base + 8'(idx)));
            ev = exp_q.pop_front();
            `CHK(cpu_vec, ev)
         end
         wb(1'b0, `OFS_TEST, 16'h0000, q);
         `CHK(q[15], exp_irq)
      end
      src <= 14'h0000;
      base <= 4'h0;
      wb(1'b1, `OFS_PRIO_21, 16'h0600, q);
      wb(1'b1, `OFS_EVT_STAT, 16'h0003, q);
      src <= 14'h0020;
      wt <= 2'($urandom);
      en <= 1'b1;
      n = 0;
      while (cpu_lvl !== 4'hF && n < 50) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 50) begin
         fails++;
         $display("[ERR] %0t request never taken", $time);
         summarize();
      end
      repeat (3) @(posedge ref_clk);
      wb(1'b0, `OFS_TEST, 16'h0000, q);
      `CHK(q, 16'h0655)
      wb(1'b0, `OFS_EVT_STAT, 16'h0000, q);
      `CHK(q[1:0], 2'b11)
      wb(1'b1, `OFS_EVT_MASK, 16'h0003, q);
      a = irq;
      wb(1'b1, `OFS_EVT_MASK, 16'h0000, q);
      `CHK(a ^ irq, 1'b1)
      wb(1'b1, `OFS_EVT_STAT, 16'h0003, q);
      `CHK(irq, 1'b0)
      wb(1'b0, `OFS_EVT_STAT, 16'h0000, q);
      `CHK(q[1:0], 2'b00)
      en <= 1'b0;
      wb(1'b1, `OFS_TEST, 16'h2000, q);
      repeat (3) @(posedge ref_clk);
      wb(1'b0, `OFS_TEST, 16'h0000, q);
      `CHK(q, 16'hA055)
      ce <= 1'b0;
      src <= 14'h0000;
      repeat (4) @(posedge ref_clk);
      `CHK(cpu_irq, 1'b1)
      ce <= 1'b1;
      repeat (3) @(posedge ref_clk);
      `CHK(cpu_irq, 1'b0)
      summarize();
   end
endmodule // interrupt_priority_and_test_regs_test
